// >>> rtl/output_driver_control.sv
/*
  Output driver control: per-driver swing, common mode, format, impedance,
  polarity and idle level, plus the combination of three active-low enable
  pins, software enables and the lock-loss disable option into one final
  enable per driver. Assumes an AXI4-Lite master on clk_sys_i, enable pins
  and lock flags asynchronous to clk_sys_i, and source clocks as levels
  from the crosspoint logic on clk_sys_i.
*/
`timescale 1ns/1ps
module output_driver_control #(
  parameter logic [6:0] PIN_MAP0_DEFAULT = 7'h7f, // stored power-up mapping
  parameter logic [6:0] PIN_MAP1_DEFAULT = 7'h00,
  parameter logic [6:0] PIN_MAP2_DEFAULT = 7'h00
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // axi4-lite write address
  input wire logic [drv_ctrl_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read address
  input wire logic [drv_ctrl_pkg::AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // enable pins and loop status, asynchronous
  input wire logic [drv_ctrl_pkg::NUM_PIN-1:0] enable_pin_n_i,
  input wire logic [drv_ctrl_pkg::NUM_LOOP-1:0] lock_lost_i,
  // source clocks from the crosspoint
  input wire logic [drv_ctrl_pkg::NUM_DRV-1:0] drv_src_i,
  // analog driver settings and pins
  output drv_ctrl_pkg::drv_cfg_s [drv_ctrl_pkg::NUM_DRV-1:0] drv_cfg_o,
  output logic [drv_ctrl_pkg::NUM_DRV-1:0] driver_true_pin_o,
  output logic [drv_ctrl_pkg::NUM_DRV-1:0] driver_comp_pin_o,
  output logic [drv_ctrl_pkg::NUM_DRV-1:0] driver_oe_n_o,
  output logic [drv_ctrl_pkg::NUM_DRV-1:0] drv_enable_o
);
  import drv_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  drv_cfg_s [NUM_DRV-1:0] cfg;           // per-driver settings
  logic [NUM_DRV-1:0] soft_en;           // per-driver software enable
  logic global_en;                       // all-driver software enable
  logic se_mask;                         // crystal-loss mask, stored only
  logic [NUM_LOOP-1:0] lol_mask;         // lock-loss disable mask
  logic [NUM_PIN-1:0][NUM_DRV-1:0] pin_map; // pin to driver mapping
  logic [NUM_DRV-1:0] pwrdn;             // per-driver power-down
  logic [NUM_PIN-1:0] pin_meta;          // first synchroniser stage
  logic [NUM_PIN-1:0] pin_sync;          // pin levels, safe to use
  logic [NUM_LOOP-1:0] lol_meta;
  logic [NUM_LOOP-1:0] lol_sync;
  logic [NUM_DRV-1:0] next_enable;       // combined enable per driver
  logic [IDX_W-1:0] wr_idx;              // held write index
  logic [31:0] wr_data;                  // held write data
  logic [3:0] wr_strb;                   // held write strobes
  logic aw_held;                         // write address captured
  logic w_held;                          // write data captured
  logic do_write;                        // both halves present, commit now
  logic wr_hit;                          // write index is mapped
  logic [31:0] next_rdata;               // read mux output
  logic rd_hit;                          // read index is mapped
  logic [IDX_W-1:0] rd_idx;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // two flops each; nothing reads the first stage but the second
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pin_meta <= '1;
      pin_sync <= '1;
      lol_meta <= '0;
      lol_sync <= '0;
    end else begin
      pin_meta <= enable_pin_n_i;
      pin_sync <= pin_meta;
      lol_meta <= lock_lost_i;
      lol_sync <= lol_meta;
    end
  end

  // ----------------------------------------------------------------
  // enable combination
  // ----------------------------------------------------------------
  // an unmapped driver is not gated by any pin; a loop select beyond the
  // four lock flags never disables, since no loop can lose lock there
  always_comb begin
    for (int d = 0; d < NUM_DRV; d++) begin
      next_enable[d] = soft_en[d] & global_en;
      for (int p = 0; p < NUM_PIN; p++) begin
        if (pin_map[p][d] && pin_sync[p]) begin
          next_enable[d] = 1'b0;
        end
      end
      if (cfg[d].loop_sel < 3'(NUM_LOOP)) begin
        if (lol_sync[cfg[d].loop_sel[1:0]] && !lol_mask[cfg[d].loop_sel[1:0]]) begin
          next_enable[d] = 1'b0;
        end
      end
    end
  end

  // registered final enables drive the lanes and the status word
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      drv_enable_o <= '0;
    end else begin
      drv_enable_o <= next_enable;
    end
  end

  // settings presented to the analog drivers, one flop stage
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      drv_cfg_o <= '0;
    end else begin
      drv_cfg_o <= cfg;
    end
  end

  // ----------------------------------------------------------------
  // output lanes
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_DRV; g++) begin : g_lane
    drv_lane u_lane (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .src_i(drv_src_i[g]),
      .enable_i(drv_enable_o[g]),
      .pwrdn_i(pwrdn[g]),
      .cfg_i(cfg[g]),
      .true_o(driver_true_pin_o[g]),
      .comp_o(driver_comp_pin_o[g]),
      .oe_n_o(driver_oe_n_o[g])
    );
  end

  // ----------------------------------------------------------------
  // axi write channels
  // ----------------------------------------------------------------
  // address and data are taken in either order; the response waits for both
  assign do_write = aw_held & w_held & ~s_axi_bvalid_o;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      aw_held <= 1'b0;
      wr_idx <= '0;
      s_axi_awready_o <= 1'b1;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      // address taken, hold off further addresses until the response
      aw_held <= 1'b1;
      wr_idx <= s_axi_awaddr_i[IDX_W+1:2];
      s_axi_awready_o <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      w_held <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_wready_o <= 1'b1;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata_i;
      wr_strb <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  // response one cycle after both halves are present
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    logic hit;
    hit = (idx == IDX_GLOBAL_EN) || (idx == IDX_SE_MASK) || (idx == IDX_LOL_MASK) ||
          (idx == IDX_PIN_MAP0) || (idx == IDX_PIN_MAP1) || (idx == IDX_PIN_MAP2) ||
          (idx == IDX_PWRDN) || (idx == IDX_STATUS);
    for (int d = 0; d < NUM_DRV; d++) begin
      hit = hit || (idx == IDX_SOFT_EN[d]) || (idx == IDX_FMT[d]) ||
            (idx == IDX_AMP[d]) || (idx == IDX_POL[d]);
    end
    return hit;
  endfunction

  assign wr_hit = idx_mapped(wr_idx);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // all writable fields lie within bits 7:0, so only byte lane 0 carries a write
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      global_en <= 1'b1;
      se_mask <= 1'b0;
      lol_mask <= LOL_MASK_RST;
      pin_map[0] <= PIN_MAP0_DEFAULT;
      pin_map[1] <= PIN_MAP1_DEFAULT;
      pin_map[2] <= PIN_MAP2_DEFAULT;
      pwrdn <= '0;
    end else if (do_write && wr_strb[0]) begin
      if (wr_idx == IDX_GLOBAL_EN) begin
        global_en <= wr_data[0];
      end
      if (wr_idx == IDX_SE_MASK) begin
        se_mask <= wr_data[SE_MASK_BIT];
      end
      if (wr_idx == IDX_LOL_MASK) begin
        lol_mask <= wr_data[NUM_LOOP-1:0];
      end
      if (wr_idx == IDX_PIN_MAP0) begin
        pin_map[0] <= wr_data[NUM_DRV-1:0];
      end
      if (wr_idx == IDX_PIN_MAP1) begin
        pin_map[1] <= wr_data[NUM_DRV-1:0];
      end
      if (wr_idx == IDX_PIN_MAP2) begin
        pin_map[2] <= wr_data[NUM_DRV-1:0];
      end
      if (wr_idx == IDX_PWRDN) begin
        pwrdn <= wr_data[NUM_DRV-1:0];
      end
    end
  end

  // per-driver registers, one loop over the seven drivers
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      for (int d = 0; d < NUM_DRV; d++) begin
        soft_en[d] <= 1'b1;
        cfg[d].format <= FMT_RST;
        cfg[d].swing <= SWING_RST;
        cfg[d].cm <= CM_RST;
        cfg[d].imp <= IMP_RST;
        cfg[d].idle <= 2'h0;
        cfg[d].pol <= POL_RST;
        cfg[d].loop_sel <= 3'h0;
      end
    end else if (do_write && wr_strb[0]) begin
      for (int d = 0; d < NUM_DRV; d++) begin
        if (wr_idx == IDX_SOFT_EN[d]) begin
          soft_en[d] <= wr_data[SOFT_EN_BIT];
        end
        if (wr_idx == IDX_FMT[d]) begin
          cfg[d].format <= wr_data[FMT_LSB +: 3];
          cfg[d].idle <= wr_data[IDLE_LSB +: 2];
          cfg[d].imp <= wr_data[IMP_LSB +: 2];
        end
        if (wr_idx == IDX_AMP[d]) begin
          cfg[d].cm <= wr_data[CM_LSB +: 4];
          cfg[d].swing <= wr_data[SWING_LSB +: 3];
        end
        if (wr_idx == IDX_POL[d]) begin
          cfg[d].loop_sel <= wr_data[LOOP_LSB +: 3];
          cfg[d].pol <= wr_data[POL_LSB +: 2];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  assign rd_idx = s_axi_araddr_i[IDX_W+1:2];
  assign rd_hit = idx_mapped(rd_idx);

  // read mux; unmapped words read zero
  always_comb begin
    next_rdata = '0;
    if (rd_idx == IDX_GLOBAL_EN) next_rdata[0] = global_en;
    if (rd_idx == IDX_SE_MASK) next_rdata[SE_MASK_BIT] = se_mask;
    if (rd_idx == IDX_LOL_MASK) next_rdata[NUM_LOOP-1:0] = lol_mask;
    if (rd_idx == IDX_PIN_MAP0) next_rdata[NUM_DRV-1:0] = pin_map[0];
    if (rd_idx == IDX_PIN_MAP1) next_rdata[NUM_DRV-1:0] = pin_map[1];
    if (rd_idx == IDX_PIN_MAP2) next_rdata[NUM_DRV-1:0] = pin_map[2];
    if (rd_idx == IDX_PWRDN) next_rdata[NUM_DRV-1:0] = pwrdn;
    if (rd_idx == IDX_STATUS) begin
      // live state: final enables, pin levels, lock flags
      next_rdata[NUM_DRV-1:0] = drv_enable_o;
      next_rdata[ST_PIN_LSB +: NUM_PIN] = pin_sync;
      next_rdata[ST_LOL_LSB +: NUM_LOOP] = lol_sync;
    end
    for (int d = 0; d < NUM_DRV; d++) begin
      if (rd_idx == IDX_SOFT_EN[d]) next_rdata[SOFT_EN_BIT] = soft_en[d];
      if (rd_idx == IDX_FMT[d]) begin
        next_rdata[FMT_LSB +: 3] = cfg[d].format;
        next_rdata[IDLE_LSB +: 2] = cfg[d].idle;
        next_rdata[IMP_LSB +: 2] = cfg[d].imp;
      end
      if (rd_idx == IDX_AMP[d]) begin
        next_rdata[CM_LSB +: 4] = cfg[d].cm;
        next_rdata[SWING_LSB +: 3] = cfg[d].swing;
      end
      if (rd_idx == IDX_POL[d]) begin
        next_rdata[LOOP_LSB +: 3] = cfg[d].loop_sel;
        next_rdata[POL_LSB +: 2] = cfg[d].pol;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

endmodule

// >>> rtl/drv_ctrl_pkg.sv
/*
  Shared constants and types for the clock output driver control block:
  register indices, field positions, reset values and the per-driver
  configuration carrier. Assumes a 32-bit AXI4-Lite register bus with
  one register per aligned word (byte address = index * 4).
*/
package drv_ctrl_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_DRV = 7;            // output drivers
  localparam int NUM_PIN = 3;            // active-low enable pins
  localparam int NUM_LOOP = 4;           // synthesis loops with lock flags
  localparam int IDX_W = 10;             // register index width
  localparam int AXI_AW = 12;            // byte address width

  // ----------------------------------------------------------------
  // register indices (byte address is four times these)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_GLOBAL_EN = 10'h102;  // [0] all-driver enable
  localparam logic [IDX_W-1:0] IDX_SE_MASK = 10'h141;    // [6] crystal-loss mask, stored only
  localparam logic [IDX_W-1:0] IDX_LOL_MASK = 10'h142;   // [3:0] lock loss mask
  localparam logic [IDX_W-1:0] IDX_PIN_MAP0 = 10'h150;   // [6:0] first pin driver map
  localparam logic [IDX_W-1:0] IDX_PIN_MAP1 = 10'h151;   // [6:0] second pin driver map
  localparam logic [IDX_W-1:0] IDX_PIN_MAP2 = 10'h152;   // [6:0] third pin driver map
  localparam logic [IDX_W-1:0] IDX_PWRDN = 10'h153;      // [6:0] driver power-down
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h154;     // read-only live state

  // per-driver register indices, driver 0 in the low slot
  typedef logic [NUM_DRV-1:0][IDX_W-1:0] idx_tab_t;
  localparam idx_tab_t IDX_SOFT_EN = {10'h13a, 10'h130, 10'h12b, 10'h126,
                                      10'h11c, 10'h117, 10'h112};
  localparam idx_tab_t IDX_FMT = {10'h13b, 10'h131, 10'h12c, 10'h127,
                                  10'h11d, 10'h118, 10'h113};
  localparam idx_tab_t IDX_AMP = {10'h13c, 10'h132, 10'h12d, 10'h128,
                                  10'h11e, 10'h119, 10'h114};
  localparam idx_tab_t IDX_POL = {10'h13d, 10'h133, 10'h12e, 10'h129,
                                  10'h11f, 10'h11a, 10'h115};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SOFT_EN_BIT = 1;        // soft enable bit in its register
  localparam int FMT_LSB = 0;            // [2:0] signal format
  localparam int IDLE_LSB = 4;           // [5:4] idle level
  localparam int IMP_LSB = 6;            // [7:6] single-ended impedance
  localparam int CM_LSB = 0;             // [3:0] common mode
  localparam int SWING_LSB = 4;          // [6:4] swing
  localparam int LOOP_LSB = 0;           // [2:0] loop selection
  localparam int POL_LSB = 6;            // [7:6] single-ended polarity
  localparam int SE_MASK_BIT = 6;        // crystal-loss mask bit
  localparam int ST_PIN_LSB = 8;         // status: synchronised pin levels
  localparam int ST_LOL_LSB = 12;        // status: synchronised lock-lost flags

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_NORMAL = 3'h1;    // differential, normal power
  localparam logic [2:0] FMT_LOW_PWR = 3'h2;   // differential, low power
  localparam logic [2:0] FMT_SINGLE = 3'h4;    // dual single-ended
  localparam logic [1:0] IDLE_HIGH = 2'h1;     // park high; any other code parks low
  localparam logic [1:0] IMP_RST = 2'h3;       // lowest impedance, valid on every supply
  localparam logic [2:0] FMT_RST = FMT_NORMAL;
  localparam logic [3:0] CM_RST = 4'h0;
  localparam logic [2:0] SWING_RST = 3'h0;
  localparam logic [1:0] POL_RST = 2'h0;       // both pins in phase
  localparam logic [3:0] LOL_MASK_RST = 4'hf;  // keep running through lock loss
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // per-driver configuration carried to the analog driver
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] format;   // signal format code
    logic [2:0] swing;    // differential swing code
    logic [3:0] cm;       // differential common mode code
    logic [1:0] imp;      // single-ended impedance code
    logic [1:0] idle;     // level held while disabled
    logic [1:0] pol;      // single-ended polarity
    logic [2:0] loop_sel; // loop feeding this driver
  } drv_cfg_s;

endpackage

// >>> rtl/drv_lane.sv
/*
  One output driver lane: forms the true and complement pin levels from
  the selected source clock, the format, polarity and idle level, and the
  final enable. Assumes src_i is a level from logic on clk_sys_i.
*/
`timescale 1ns/1ps
module drv_lane (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // control
  input wire logic src_i,
  input wire logic enable_i,
  input wire logic pwrdn_i,
  input wire drv_ctrl_pkg::drv_cfg_s cfg_i,
  // pins
  output logic true_o,
  output logic comp_o,
  output logic oe_n_o
);
  import drv_ctrl_pkg::*;

  logic single;      // dual single-ended mode
  logic idle_lvl;    // parked level
  logic next_true;
  logic next_comp;

  assign single = (cfg_i.format == FMT_SINGLE);
  assign idle_lvl = (cfg_i.idle == IDLE_HIGH);

  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  // differential drives a complementary pair; single-ended drives both pins
  always_comb begin
    if (!enable_i) begin
      // parked, static, floating only when powered down
      next_true = idle_lvl;
      next_comp = single ? idle_lvl : ~idle_lvl;
    end else if (single) begin
      // in phase by default, polarity field flips either pin
      next_true = src_i ^ cfg_i.pol[1];
      next_comp = src_i ^ cfg_i.pol[0];
    end else begin
      next_true = src_i;
      next_comp = ~src_i;
    end
  end

  // registered pins; power-down releases the pins entirely
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      // reset format is differential parked low, so the pair stays complementary
      true_o <= 1'b0;
      comp_o <= 1'b1;
      oe_n_o <= 1'b1;
    end else begin
      true_o <= next_true;
      comp_o <= next_comp;
      oe_n_o <= pwrdn_i;
    end
  end

endmodule

// >>> tb/output_driver_control_assertions.sv
/* checker: enable gating, idle levels, polarity, bus turn-around.
   sees top ports only; assumes the first pin keeps its full default map. */
`timescale 1ns/1ps
module output_driver_control_checker (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // bus handshakes
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // pins and drivers
  input wire logic [drv_ctrl_pkg::NUM_PIN-1:0] enable_pin_n_i,
  input wire drv_ctrl_pkg::drv_cfg_s [drv_ctrl_pkg::NUM_DRV-1:0] drv_cfg_o,
  input wire logic [drv_ctrl_pkg::NUM_DRV-1:0] driver_true_pin_o,
  input wire logic [drv_ctrl_pkg::NUM_DRV-1:0] driver_comp_pin_o,
  input wire logic [drv_ctrl_pkg::NUM_DRV-1:0] drv_enable_o
);
  import drv_ctrl_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // pins lag the enable by one edge, hence the two-cycle windows
  pin_gate_a: assert property (
    enable_pin_n_i[0] [*3] |=> drv_enable_o == '0) else $error("enable with pin high");
  rise_cause_a: assert property (
    $rose(drv_enable_o[0]) |-> !$past(enable_pin_n_i[0], 3)) else $error("enable no pin");
  idle_level_a: assert property (
    (!drv_enable_o[0] && $stable(drv_cfg_o[0])) [*2]
    |-> driver_true_pin_o[0] == (drv_cfg_o[0].idle == IDLE_HIGH)) else $error("idle level");
  diff_idle_a: assert property (
    (!drv_enable_o[0] && drv_cfg_o[0].format != FMT_SINGLE && $stable(drv_cfg_o[0])) [*2]
    |-> driver_comp_pin_o[0] != driver_true_pin_o[0]) else $error("idle pins equal");
  se_pol_a: assert property (
    (drv_enable_o[0] && drv_cfg_o[0].format == FMT_SINGLE && $stable(drv_cfg_o[0])) [*2]
    |-> (driver_true_pin_o[0] ^ driver_comp_pin_o[0]) == ^drv_cfg_o[0].pol)
    else $error("single-ended polarity");
  write_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("second write taken");
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("read not answered");
  read_done_a: assert property (s_axi_rvalid_o && s_axi_rready_i
    |=> !s_axi_rvalid_o && s_axi_arready_o) else $error("read not released");
endmodule

bind output_driver_control output_driver_control_checker chk_u (.*);

// >>> tb/clk_receiver.sv
/* downstream receiver model: counts edges on the first true pin while driven.
   assumes pin levels change on clk_sys_i. */
`timescale 1ns/1ps
module clk_receiver (
  // clock and control
  input wire logic clk_sys_i,
  input wire logic clr_i,
  // driver pins
  input wire logic [6:0] true_i,
  input wire logic [6:0] oe_n_i,
  // observation
  output logic [15:0] toggles_o
);
  logic last; // previous pin level
  // a powered-down pin floats, so its edges are not counted
  always_ff @(posedge clk_sys_i) begin
    last <= true_i[0];
    toggles_o <= clr_i ? 16'h0000 : toggles_o + 16'(last != true_i[0] && !oe_n_i[0]);
  end
endmodule

// >>> tb/output_driver_control_test.sv
/* testbench: registers over the bus, pin and register enables, idle, lock loss.
   assumes a 200 MHz clock and the receiver model beside the block. */
`timescale 1ns/1ps
module output_driver_control_test;
  import drv_ctrl_pkg::*;
  logic clk_sys_i = 0, nrst_i = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, clr = 1, awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic [1:0] bresp, rresp;
  logic [2:0] pin_n = '0;
  logic [3:0] lock_lost = '0;
  logic [6:0] src = '0, tp, cp, oe_n, en;
  logic [15:0] toggles;
  drv_cfg_s [6:0] cfg;
  int fail_count = 0, tests_run = 0, seed = 32'h35b6_021d;
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) src <= 7'($random(seed));
  output_driver_control uut (.clk_sys_i, .nrst_i, .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .enable_pin_n_i(pin_n), .lock_lost_i(lock_lost), .drv_src_i(src),
    .drv_cfg_o(cfg), .driver_true_pin_o(tp), .driver_comp_pin_o(cp),
    .driver_oe_n_o(oe_n), .drv_enable_o(en));
  clk_receiver rx (.clk_sys_i, .clr_i(clr), .true_i(tp), .oe_n_i(oe_n), .toggles_o(toggles));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // each channel drops its valid at the edge where its ready was seen
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_sys_i);
    awaddr <= {i, 2'b00};
    wdata <= 32'(d);
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    forever begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    chk(32'(bresp), 32'(er));
    bready <= 0;
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_sys_i);
    araddr <= {i, 2'b00};
    arvalid <= 1;
    rready <= 1;
    forever begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    rready <= 0;
  endtask
  // pins need three edges through the synchronisers
  task automatic settle;
    repeat (5) @(posedge clk_sys_i);
  endtask
  // format byte per driver: impedance 1..3, idle, format rotated
  function automatic logic [7:0] fmt_of(int d);
    return {2'(1 + d % 3), 2'(d), 1'b0, ((d % 3 == 0) ? FMT_SINGLE : 3'(d % 3))};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1;
    rd(IDX_FMT[0], 32'h0000_00c1, RESP_OKAY);
    rd(IDX_LOL_MASK, 32'h0000_000f, RESP_OKAY);
    rd(IDX_PIN_MAP0, 32'h0000_007f, RESP_OKAY);
    rd(IDX_PIN_MAP1, 32'h0000_0000, RESP_OKAY);
    $display("reset values done");
    for (int d = 0; d < 7; d++) begin
      v = 32'($random(seed)) & 32'h0000_007f;
      wr(IDX_FMT[d], fmt_of(d), RESP_OKAY);
      wr(IDX_AMP[d], v[7:0], RESP_OKAY);
      wr(IDX_POL[d], {v[1:0], 6'h00}, RESP_OKAY);
      rd(IDX_FMT[d], 32'(fmt_of(d)), RESP_OKAY);
      rd(IDX_AMP[d], v, RESP_OKAY);
      chk(32'({cfg[d].swing, cfg[d].cm}), v);
      chk(32'(cfg[d].pol), 32'(v[1:0]));
    end
    wr(10'h3ff, 8'hff, RESP_SLVERR);
    rd(10'h3ff, 32'h0000_0000, RESP_SLVERR);
    $display("register tests done");
    pin_n <= 3'b110;
    settle;
    chk(32'(en), 32'h0000_007f);
    wr(IDX_SOFT_EN[2], 8'h00, RESP_OKAY);
    wr(IDX_PIN_MAP1, 8'h08, RESP_OKAY);
    settle;
    chk(32'(en), 32'h0000_0073);
    pin_n <= 3'b111;
    wr(IDX_FMT[0], 8'hd1, RESP_OKAY);
    settle;
    chk(32'({en, tp[0], cp[0]}), 32'h0000_0002);
    pin_n <= 3'b000;
    lock_lost <= 4'h1;
    settle;
    clr <= 0;
    repeat (40) @(posedge clk_sys_i);
    chk(32'({en, toggles != 0}), 32'h0000_00f7);
    wr(IDX_LOL_MASK, 8'h0e, RESP_OKAY);
    settle;
    chk(32'(en), 32'h0000_0000);
    lock_lost <= 4'h0;
    wr(IDX_PWRDN, 8'h01, RESP_OKAY);
    settle;
    chk(32'({oe_n, en}), 32'h0000_00fb);
    rd(IDX_STATUS, 32'h0000_007b, RESP_OKAY);
    wr(IDX_GLOBAL_EN, 8'h00, RESP_OKAY);
    settle;
    chk(32'(en), 32'h0000_0000);
    $display("enable tests done");
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    summarize;
  end
endmodule
